// file: logic/sphpt_top.sv
// Setpoint deadband comparison, display flash, setpoint edit cycle and
// peak/valley tracking, with an APB register port.
// Assumes keys are one-cycle pulses and readings arrive with a valid strobe,
// all synchronous to clk.
//
// The implementer's own choices: register access over APB and the placing of the registers.
module sphpt_top #(
    parameter logic [31:0] INTERVAL_CYCLES = 32'(sphpt_pkg::INTERVAL_CYCLES),
    parameter logic [31:0] NUMBER_CYCLES = 32'(sphpt_pkg::NUMBER_CYCLES)
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Front panel and measurement stream
    input wire sphpt_pkg::sphpt_keys_t keys,
    input wire sphpt_pkg::sphpt_reading_t reading,
    // Status outputs
    output logic [3:0] limit_active,
    output logic display_flash,
    output logic [15:0] coded_out,
    output sphpt_pkg::sphpt_mode_t mode,
    output logic show_number,
    output logic [1:0] edit_index,
    output logic [1:0] edit_digit,
    output logic [15:0] edit_value
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [15:0] stage_limit [4];
    logic [15:0] stage_pdb;
    logic [15:0] stage_adb;
    logic [7:0] stage_delay [2];
    logic [15:0] act_limit [4];
    logic [15:0] act_pdb;
    logic [15:0] act_adb;
    logic [7:0] act_delay [2];
    logic [7:0] run_len [2];
    logic signed [15:0] peak;
    logic signed [15:0] valley;
    logic [31:0] timer;
    logic edited;
    logic [3:0] set_hit;
    logic [3:0] clr_hit;
    logic apb_wr;
    logic apb_acc;
    logic commit;
    logic restart;
    logic store;
    logic [2:0] flash_sel;
    logic [3:0] dir;

    // Threshold check; split selects even deadband, else all on inactive side
    function automatic logic [1:0] judge(input logic below, input logic signed [15:0] r,
        input logic [15:0] lvl, input logic [15:0] db, input logic split);
        logic signed [17:0] rv;
        logic signed [17:0] lv;
        logic signed [17:0] so;
        logic signed [17:0] ro;
        rv = 18'(r);
        lv = 18'(signed'(lvl));
        so = split ? 18'({2'b00, db[15:1]}) : 18'h0_0000;
        ro = split ? 18'({2'b00, db[15:1]}) : 18'({2'b00, db});
        if (below)
            judge = {rv < lv - so, rv > lv + ro};
        else
            judge = {rv > lv + so, rv < lv - ro};
    endfunction

    // Add one to the nibble at edit position 0 (leftmost) to 3
    function automatic logic [15:0] bump(input logic [15:0] v, input logic [1:0] pos);
        logic [3:0] sh;
        sh = {2'b11 - pos, 2'b00};
        bump = (v & ~(16'h000F << sh)) | ((((v >> sh) + 16'h0001) & 16'h000F) << sh);
    endfunction

    assign flash_sel = ctrl[sphpt_pkg::CTRL_FLASH_LSB +: 3];
    assign dir = ctrl[sphpt_pkg::CTRL_DIR_LSB +: 4];
    assign apb_acc = psel & penable & ~pready;
    assign apb_wr = psel & penable & pready & pwrite & ~pslverr;
    assign store = apb_wr & (paddr == sphpt_pkg::OFF_CTRL) & pwdata[sphpt_pkg::CTRL_STORE_BIT];
    // Reset in the same cycle abandons the edit, so it must block the commit
    assign commit = (mode == sphpt_pkg::MODE_CYCLE) & keys.limit_view & edited & ~keys.reset;
    assign restart = (mode == sphpt_pkg::MODE_PEAK || mode == sphpt_pkg::MODE_VALLEY) & keys.reset;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // One wait state: ready rises in the second access cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready <= apb_acc;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (apb_acc)
            begin
                unique case (paddr)
                    sphpt_pkg::OFF_CTRL: prdata <= ctrl;
                    sphpt_pkg::OFF_DEADBAND: prdata <= {stage_adb, stage_pdb};
                    sphpt_pkg::OFF_DELAY: prdata <= {16'h0000, stage_delay[1], stage_delay[0]};
                    sphpt_pkg::OFF_LIMIT0: prdata <= {16'h0000, act_limit[0]};
                    sphpt_pkg::OFF_LIMIT1: prdata <= {16'h0000, act_limit[1]};
                    sphpt_pkg::OFF_LIMIT2: prdata <= {16'h0000, act_limit[2]};
                    sphpt_pkg::OFF_LIMIT3: prdata <= {16'h0000, act_limit[3]};
                    sphpt_pkg::OFF_STATUS: prdata <= {25'h000_0000, mode, display_flash, limit_active};
                    sphpt_pkg::OFF_PEAK: prdata <= {16'h0000, peak};
                    sphpt_pkg::OFF_VALLEY: prdata <= {16'h0000, valley};
                    sphpt_pkg::OFF_EDIT: prdata <= {12'h000, edit_index, edit_digit, edit_value};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Staged deadband, delay and limits, plus the control word that acts at once; store bit is self-clearing
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl <= sphpt_pkg::CTRL_RESET;
            stage_pdb <= sphpt_pkg::DB_RESET;
            stage_adb <= sphpt_pkg::DB_RESET;
            stage_delay <= '{default: sphpt_pkg::DELAY_RESET};
            stage_limit <= '{default: sphpt_pkg::LIMIT_RESET};
        end
        else if (ce)
        begin
            if (commit)
                stage_limit[edit_index] <= edit_value;
            if (apb_wr)
            begin
                unique case (paddr)
                    sphpt_pkg::OFF_CTRL: ctrl <= pwdata & ~32'h0000_0001;
                    sphpt_pkg::OFF_DEADBAND:
                    begin
                        stage_pdb <= pwdata[15:0];
                        stage_adb <= pwdata[sphpt_pkg::DB_ALARM_LSB +: 16];
                    end
                    sphpt_pkg::OFF_DELAY:
                    begin
                        stage_delay[0] <= pwdata[7:0];
                        stage_delay[1] <= pwdata[sphpt_pkg::DELAY_B_LSB +: 8];
                    end
                    sphpt_pkg::OFF_LIMIT0: stage_limit[0] <= pwdata[15:0];
                    sphpt_pkg::OFF_LIMIT1: stage_limit[1] <= pwdata[15:0];
                    sphpt_pkg::OFF_LIMIT2: stage_limit[2] <= pwdata[15:0];
                    sphpt_pkg::OFF_LIMIT3: stage_limit[3] <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // Active settings, loaded on store; an edit commit loads only the edited limit
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            act_pdb <= sphpt_pkg::DB_RESET;
            act_adb <= sphpt_pkg::DB_RESET;
            act_delay <= '{default: sphpt_pkg::DELAY_RESET};
            act_limit <= '{default: sphpt_pkg::LIMIT_RESET};
        end
        else if (ce)
        begin
            if (store)
            begin
                act_pdb <= stage_pdb;
                act_adb <= stage_adb;
                act_delay <= stage_delay;
                act_limit <= stage_limit;
            end
            else if (commit)
                act_limit[edit_index] <= edit_value;
        end
    end

    // ------------------------------------------------------------
    // Setpoint comparisons
    // ------------------------------------------------------------
    // Deadband is raw reading units, so its decimal point tracks the reading
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            {set_hit[i], clr_hit[i]} = (i < 2)
                ? judge(dir[i], reading.value, act_limit[i], act_pdb, 1'b1)
                : judge(dir[i], reading.value, act_limit[i], act_adb, 1'b0);
        end
    end

    // Activity only moves on a reading strobe
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            limit_active <= 4'h0;
            run_len <= '{default: 8'h00};
        end
        else if (ce && reading.valid)
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (set_hit[i])
                    limit_active[i] <= 1'b1;
                else if (clr_hit[i])
                    limit_active[i] <= 1'b0;
            end
            for (int j = 0; j < 2; j++)
            begin
                if (set_hit[j + 2])
                begin
                    // Saturate so a long excursion never wraps the count
                    if (run_len[j] != 8'hFF)
                        run_len[j] <= run_len[j] + 8'h01;
                    if (run_len[j] + 9'h001 >= {1'b0, act_delay[j]})
                        limit_active[j + 2] <= 1'b1;
                end
                else
                begin
                    run_len[j] <= 8'h00;
                    if (clr_hit[j + 2])
                        limit_active[j + 2] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Mode control and setpoint edit cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode <= sphpt_pkg::MODE_RUN;
            timer <= 32'h0000_0000;
            edit_index <= 2'b00;
            edit_digit <= 2'b00;
            edit_value <= sphpt_pkg::LIMIT_RESET;
            edited <= 1'b0;
        end
        else if (ce)
        begin
            unique case (mode)
                sphpt_pkg::MODE_RUN:
                begin
                    if (keys.limit_view)
                    begin
                        mode <= sphpt_pkg::MODE_CYCLE;
                        timer <= 32'h0000_0000;
                        edit_index <= 2'b00;
                        edit_digit <= 2'b00;
                        edit_value <= act_limit[0];
                        edited <= 1'b0;
                    end
                    else if (keys.incr && !ctrl[sphpt_pkg::CTRL_HI_LOCK_BIT] &&
                             !ctrl[sphpt_pkg::CTRL_LO_LOCK_BIT])
                        mode <= sphpt_pkg::MODE_PEAK;
                    else if (keys.shift && !ctrl[sphpt_pkg::CTRL_HI_LOCK_BIT] &&
                             !ctrl[sphpt_pkg::CTRL_LO_LOCK_BIT])
                        mode <= sphpt_pkg::MODE_VALLEY;
                end
                sphpt_pkg::MODE_CYCLE:
                begin
                    // Reset abandons the edit; nothing is written back
                    if (keys.reset)
                        mode <= sphpt_pkg::MODE_RUN;
                    else if (keys.limit_view || timer >= INTERVAL_CYCLES - 32'h1)
                    begin
                        timer <= 32'h0000_0000;
                        edit_digit <= 2'b00;
                        edited <= 1'b0;
                        edit_index <= edit_index + 2'b01;
                        edit_value <= act_limit[edit_index + 2'b01];
                        if (edit_index == 2'b11)
                            mode <= sphpt_pkg::MODE_RUN;
                    end
                    else if (keys.shift || keys.incr)
                    begin
                        timer <= 32'h0000_0000;
                        if (keys.shift)
                            edit_digit <= edit_digit + 2'b01;
                        else
                        begin
                            edit_value <= bump(edit_value, edit_digit);
                            edited <= 1'b1;
                        end
                    end
                    else
                        timer <= timer + 32'h0000_0001;
                end
                sphpt_pkg::MODE_PEAK, sphpt_pkg::MODE_VALLEY:
                begin
                    // View has no timeout; only keys leave it
                    if (keys.limit_view || keys.config_store || keys.reset)
                        mode <= sphpt_pkg::MODE_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Peak and valley tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst || (ce && restart))
        begin
            peak <= signed'(sphpt_pkg::PEAK_INIT);
            valley <= signed'(sphpt_pkg::VALLEY_INIT);
        end
        else if (ce && reading.valid)
        begin
            if (reading.value > peak)
                peak <= reading.value;
            if (reading.value < valley)
                valley <= reading.value;
        end
    end

    // ------------------------------------------------------------
    // Display and coded outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            display_flash <= 1'b0;
            show_number <= 1'b0;
            coded_out <= 16'h0000;
        end
        else if (ce)
        begin
            show_number <= (mode == sphpt_pkg::MODE_CYCLE) && (timer < NUMBER_CYCLES);
            if (mode == sphpt_pkg::MODE_PEAK || mode == sphpt_pkg::MODE_VALLEY)
                display_flash <= 1'b1;
            else if (flash_sel == sphpt_pkg::FLASH_ANY)
                display_flash <= |limit_active;
            else if (flash_sel == sphpt_pkg::FLASH_OFF || flash_sel > sphpt_pkg::FLASH_ANY)
                display_flash <= 1'b0;
            else
                display_flash <= limit_active[2'(flash_sel - 3'h1)];
            // Valley is deliberately not selectable here
            coded_out <= ctrl[sphpt_pkg::CTRL_PEAK_OUT_BIT] ? peak : reading.value;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    chk_alarm_zero_delay: assert property (
        reading.valid && set_hit[2] && act_delay[0] == 8'h00 |=> limit_active[2])
        else $error("alarm not asserted on first reading");
    chk_band_holds: assert property (
        reading.valid && !set_hit[0] && !clr_hit[0] |=> $stable(limit_active[0]))
        else $error("setpoint moved inside deadband");
    chk_strobe_only: assert property (
        !reading.valid |=> $stable(limit_active))
        else $error("activity changed without reading");
    chk_peak_follow: assert property (
        reading.valid && reading.value > peak && !restart |=> peak == $past(reading.value))
        else $error("peak not updated");
    chk_restart_init: assert property (
        restart |=> peak == signed'(sphpt_pkg::PEAK_INIT) && mode == sphpt_pkg::MODE_RUN)
        else $error("restart did not reinit");
    chk_lockout_view: assert property (
        mode == sphpt_pkg::MODE_RUN && keys.incr && ctrl[sphpt_pkg::CTRL_HI_LOCK_BIT]
        |=> mode != sphpt_pkg::MODE_PEAK)
        else $error("locked peak shown");
    chk_commit_value: assert property (
        commit && !store |=> act_limit[$past(edit_index)] == $past(edit_value))
        else $error("commit lost");
    chk_edit_timer: assert property (
        mode == sphpt_pkg::MODE_CYCLE && keys.shift && !keys.reset && !keys.limit_view
        && timer < INTERVAL_CYCLES - 32'h1 |=> timer == 32'h0000_0000)
        else $error("timer not restarted");
    chk_flash_any: assert property (
        mode == sphpt_pkg::MODE_RUN && flash_sel == sphpt_pkg::FLASH_ANY |=>
        display_flash == |$past(limit_active))
        else $error("flash any wrong");
    cov_cycle: cover property (mode == sphpt_pkg::MODE_RUN ##1 mode == sphpt_pkg::MODE_CYCLE);
    cov_commit: cover property (commit);
    cov_restart: cover property (restart);
endmodule // sphpt_top

// file: shared/sphpt_pkg.sv
// Shared constants and types for the setpoint, deadband and peak tracker.
// Assumes one 250 MHz clock and an APB slave port with 32-bit data.
package sphpt_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DEADBAND = 8'h04;
    localparam logic [7:0] OFF_DELAY = 8'h08;
    localparam logic [7:0] OFF_LIMIT0 = 8'h0C;
    localparam logic [7:0] OFF_LIMIT1 = 8'h10;
    localparam logic [7:0] OFF_LIMIT2 = 8'h14;
    localparam logic [7:0] OFF_LIMIT3 = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [7:0] OFF_PEAK = 8'h20;
    localparam logic [7:0] OFF_VALLEY = 8'h24;
    localparam logic [7:0] OFF_EDIT = 8'h28;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_STORE_BIT = 0;
    localparam int CTRL_DIR_LSB = 1;
    localparam int CTRL_FLASH_LSB = 5;
    localparam int CTRL_HI_LOCK_BIT = 8;
    localparam int CTRL_LO_LOCK_BIT = 9;
    localparam int CTRL_PEAK_OUT_BIT = 10;
    localparam int DB_ALARM_LSB = 16;
    localparam int DELAY_B_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;
    localparam logic [15:0] DB_RESET = 16'h0000;
    localparam logic [7:0] DELAY_RESET = 8'h00;
    localparam logic [15:0] PEAK_INIT = 16'h8000;
    localparam logic [15:0] VALLEY_INIT = 16'h7FFF;
    // ------------------------------------------------------------
    // Flash select codes and timing
    // ------------------------------------------------------------
    localparam logic [2:0] FLASH_OFF = 3'h0;
    localparam logic [2:0] FLASH_ANY = 3'h5;
    localparam longint unsigned CLK_HZ = 64'd250_000_000;
    localparam longint unsigned INTERVAL_S = 64'd15;
    localparam longint unsigned INTERVAL_CYCLES = INTERVAL_S * CLK_HZ;
    localparam longint unsigned NUMBER_MS = 64'd1000;
    localparam longint unsigned NUMBER_CYCLES = NUMBER_MS * CLK_HZ / 64'd1000;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic limit_view;
        logic config_store;
        logic reset;
        logic incr;
        logic shift;
    } sphpt_keys_t;
    typedef struct packed {
        logic signed [15:0] value;
        logic valid;
    } sphpt_reading_t;
    typedef enum logic [1:0] {MODE_RUN, MODE_CYCLE, MODE_PEAK, MODE_VALLEY} sphpt_mode_t;
endpackage

// file: sim/sphpt_panel_model.sv
// Front-panel keys and measurement stream for the tracker.
// Assumes clk is the tracker clock; every change follows a rising edge.
module sphpt_panel_model (
    // Clock
    input wire logic clk,
    // Toward the tracker
    output sphpt_pkg::sphpt_keys_t keys,
    output sphpt_pkg::sphpt_reading_t reading
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle panel at time zero
    initial
    begin
        keys = '0;
        reading = '0;
    end
    // One-cycle press, as a debounced key gives
    task automatic press(input logic [4:0] k);
        @(posedge clk);
        keys <= k;
        @(posedge clk);
        keys <= '0;
    endtask
    // One-cycle strobe; value inverted after so a stale sample shows
    task automatic send(input logic [15:0] v);
        @(posedge clk);
        reading <= {v, 1'b1};
        @(posedge clk);
        reading <= {~v, 1'b0};
    endtask
endmodule // sphpt_panel_model

// file: sim/testbench.sv
// Self-checking bench for the setpoint and peak tracker.
// Assumes the panel model drives keys and readings; APB is driven here.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] KV = 5'h10, KS = 5'h08, KR = 5'h04, KI = 5'h02, KH = 5'h01;
    logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, display_flash, show_number, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] limit_active;
    logic [15:0] coded_out, edit_value;
    logic [1:0] edit_index, edit_digit;
    sphpt_pkg::sphpt_mode_t mode;
    sphpt_pkg::sphpt_keys_t keys;
    sphpt_pkg::sphpt_reading_t reading;
    int error_cnt = 0;
    int checks_done = 0;
    // Short interval so the whole edit cycle fits the run
    sphpt_top #(.INTERVAL_CYCLES(32'd200), .NUMBER_CYCLES(32'd20)) sphpt_top_inst (.clk(clk), .rst(rst),
        .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .keys(keys), .reading(reading),
        .limit_active(limit_active), .display_flash(display_flash), .coded_out(coded_out), .mode(mode),
        .show_number(show_number), .edit_index(edit_index), .edit_digit(edit_digit), .edit_value(edit_value));
    sphpt_panel_model sphpt_panel_model_inst (.clk(clk), .keys(keys), .reading(reading));
    // ------------------------------------------------------------
    // Bus, compare and closing tasks
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50)
            error_cnt++;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, exp);
    endtask
    // Reading in, then one active bit judged once it has settled
    task automatic feed(input logic [15:0] v, input int b, input logic e);
        sphpt_panel_model_inst.send(v);
        @(negedge clk);
        chk(32'(limit_active[b]), 32'(e));
    endtask
    task automatic key(input logic [4:0] k, input sphpt_pkg::sphpt_mode_t m);
        sphpt_panel_model_inst.press(k);
        @(negedge clk);
        chk(32'(mode), 32'(m));
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_levels;
        int c;
        logic [7:0] fl;
        rdchk(sphpt_pkg::OFF_PEAK, 32'h0000_8000);
        rdchk(8'h40, 32'h0000_0000);
        chk(32'(rerr), 32'h0000_0001);
        apb(1'b1, sphpt_pkg::OFF_LIMIT0, 32'h0000_0064);
        apb(1'b1, sphpt_pkg::OFF_LIMIT2, 32'h0000_0064);
        apb(1'b1, sphpt_pkg::OFF_DEADBAND, 32'h0014_0014);
        apb(1'b1, sphpt_pkg::OFF_CTRL, 32'h0000_0001);
        feed(16'd110, 0, 1'b0);
        feed(16'd111, 0, 1'b1);
        feed(16'd90, 0, 1'b1);
        feed(16'd89, 0, 1'b0);
        feed(16'd101, 2, 1'b1);
        feed(16'd80, 2, 1'b1);
        feed(16'd79, 2, 1'b0);
        apb(1'b1, sphpt_pkg::OFF_DELAY, 32'h0000_0003);
        apb(1'b1, sphpt_pkg::OFF_CTRL, 32'h0000_0001);
        feed(16'd101, 2, 1'b0);
        feed(16'd101, 2, 1'b0);
        feed(16'd101, 2, 1'b1);
        // Active now: 1110, so codes 2 to 5 flash and 0, 1, 6, 7 stay dark
        fl = 8'b0011_1100;
        for (c = 0; c < 8; c++)
        begin
            apb(1'b1, sphpt_pkg::OFF_CTRL, 32'((c << 5) | 1));
            repeat (2) @(negedge clk);
            chk(32'(display_flash), 32'(fl[c]));
        end
        // First setpoint turned to active below: set under 90, clear over 110
        apb(1'b1, sphpt_pkg::OFF_CTRL, 32'h0000_0003);
        feed(16'd89, 0, 1'b1);
        feed(16'd111, 0, 1'b0);
        $display("levels test done");
    endtask
    task automatic t_extremes;
        rdchk(sphpt_pkg::OFF_VALLEY, 32'h0000_004F);
        key(KI, sphpt_pkg::MODE_PEAK);
        @(negedge clk);
        chk(32'(display_flash), 32'h0000_0001);
        sphpt_panel_model_inst.send(16'd200);
        rdchk(sphpt_pkg::OFF_PEAK, 32'h0000_00C8);
        key(KS, sphpt_pkg::MODE_RUN);
        rdchk(sphpt_pkg::OFF_PEAK, 32'h0000_00C8);
        apb(1'b1, sphpt_pkg::OFF_CTRL, 32'h0000_0400);
        repeat (2) @(negedge clk);
        chk(32'(coded_out), 32'h0000_00C8);
        key(KH, sphpt_pkg::MODE_VALLEY);
        key(KR, sphpt_pkg::MODE_RUN);
        rdchk(sphpt_pkg::OFF_VALLEY, 32'h0000_7FFF);
        // A strobe while the enable is low must leave the extremes alone
        @(posedge clk);
        ce <= 1'b0;
        sphpt_panel_model_inst.send(16'd300);
        ce <= 1'b1;
        rdchk(sphpt_pkg::OFF_PEAK, 32'h0000_8000);
        apb(1'b1, sphpt_pkg::OFF_CTRL, 32'h0000_0101);
        key(KI, sphpt_pkg::MODE_RUN);
        $display("extremes test done");
    endtask
    task automatic t_edit;
        key(KV, sphpt_pkg::MODE_CYCLE);
        @(negedge clk);
        chk({show_number, edit_index, edit_value}, 32'h0004_0064);
        key(KI, sphpt_pkg::MODE_CYCLE);
        key(KH, sphpt_pkg::MODE_CYCLE);
        key(KI, sphpt_pkg::MODE_CYCLE);
        chk({edit_digit, edit_value}, 32'h0001_1164);
        key(KV, sphpt_pkg::MODE_CYCLE);
        rdchk(sphpt_pkg::OFF_LIMIT0, 32'h0000_1164);
        key(KI, sphpt_pkg::MODE_CYCLE);
        key(KR, sphpt_pkg::MODE_RUN);
        rdchk(sphpt_pkg::OFF_LIMIT1, 32'h0000_0000);
        key(KV, sphpt_pkg::MODE_CYCLE);
        key(KI, sphpt_pkg::MODE_CYCLE);
        repeat (25) @(negedge clk);
        chk(32'(show_number), 32'h0000_0000);
        repeat (805) @(negedge clk);
        chk(32'(mode), 32'(sphpt_pkg::MODE_RUN));
        rdchk(sphpt_pkg::OFF_LIMIT0, 32'h0000_1164);
        $display("edit test done");
    endtask
    // Reset held eight cycles, then the scenarios in turn
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_levels();
        t_extremes();
        t_edit();
        complete_run();
    end
    // Watchdog well past the expected run of about a thousand cycles
    initial
    begin
        #200000;
        error_cnt++;
        complete_run();
    end
endmodule // testbench
